// >>> hw/mvic_pkg.sv
// Package with constants and types for the vectored interrupt controller
`default_nettype none
package mvic_pkg;
  localparam int             NUM_SRC      = 16;
  localparam int             NUM_VEC      = 10;
  localparam int             NUM_PINS     = 6;
  localparam int             VEC_W        = 20;
  localparam int             IDX_W        = 4;
  localparam logic [19:0]    VEC_BASE     = 20'h00003;
  localparam logic [19:0]    VEC_STEP     = 20'h00008;
  localparam int             FILT_LEN     = 3;
  // Source bit positions inside the source flag word
  localparam int             SRC_PIN_A    = 0;
  localparam int             SRC_PIN_B    = 1;
  localparam int             SRC_PIN_C    = 2;
  localparam int             SRC_T0L      = 3;
  localparam int             SRC_PIN_E    = 4;
  localparam int             SRC_PIN_D    = 5;
  localparam int             SRC_PIN_F    = 6;
  localparam int             SRC_T0H      = 7;
  localparam int             SRC_SIO      = 8;
  localparam int             SRC_T1L      = 9;
  localparam int             SRC_T1H      = 10;
  localparam int             SRC_PULSE_COUNTER1_EVENT     = 11;
  localparam int             SRC_PULSE_COUNTER2_EVENT     = 12;
  localparam int             SRC_ADC      = 13;
  localparam int             SRC_PWM_STOP = 14;
  localparam int             SRC_PWM_CYC  = 15;
  // Pin positions in the pin words
  localparam int             PIN_A        = 0;
  localparam int             PIN_B        = 1;
  localparam int             PIN_C        = 2;
  // Reset values
  localparam logic [2:0]     INSVC_RST    = 3'h0;
  localparam logic [2:0]     FILT_RST     = 3'h0;

  typedef enum logic [1:0] {LVL_NONE, LVL_L, LVL_H, LVL_X} mvic_lvl_type;

  typedef enum logic [1:0] {SB_RUN, SB_HALT, SB_HOLD} mvic_sb_type;

  typedef enum logic {OF_IDLE, OF_OFFER} mvic_of_type;

  typedef struct packed {
    logic [19:0]  vector;
    mvic_lvl_type level;
  } mvic_offer_type;
endpackage : mvic_pkg
`default_nettype wire

// >>> hw/mvic_arbiter.sv
// Picks the winning vector: highest level first, then lowest vector index
`default_nettype none
module mvic_arbiter #(
  parameter int N = 10
) (
  input  wire logic [N-1:0]          req,
  input  wire mvic_pkg::mvic_lvl_type lvl [N],
  output logic                       found,
  output logic [3:0]                 idx,
  output mvic_pkg::mvic_lvl_type     level
);
  import mvic_pkg::*;

  // Scan downward so an equal level at a lower index overrides
  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    level = LVL_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (lvl[i] >= level)) begin
        found = 1'b1;
        idx   = 4'(i);
        level = lvl[i];
      end
    end
  end
endmodule // mvic_arbiter
`default_nettype wire

// >>> hw/mvic_top.sv
// Multilevel vectored interrupt controller with standby control
`default_nettype none
module mvic_top (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  input  wire logic [15:0]             SRC_FLAGS,
  input  wire logic [9:0]              LEVEL_UPPER,
  input  wire logic                    IRQ_ACK,
  input  wire logic                    IRQ_RETURN,
  output logic                         IRQ_REQ,
  output mvic_pkg::mvic_offer_type     IRQ_OFFER,
  output logic [2:0]                   IN_SERVICE,
  input  wire logic                    HALT_ENTER,
  input  wire logic                    HOLD_ENTER,
  input  wire logic [5:0]              EXT_PIN,
  input  wire logic [5:0]              PIN_LEVEL_HIGH,
  input  wire logic [1:0]              PIN_AB_LEVEL_MODE,
  input  wire logic                    CMP_OUT,
  input  wire logic                    CMP_TO_PIN_C,
  input  wire logic                    PIN_C_FILTER_EN,
  input  wire logic                    PIN_C_RISE,
  input  wire logic                    PIN_C_FALL,
  input  wire logic                    PIN_C_FLAG_CLR,
  output logic                         PIN_C_FLAG,
  input  wire logic                    RST_PIN_N,
  input  wire logic                    WDT_RESET,
  input  wire logic                    BOD_RESET,
  output logic                         CPU_RUN,
  output logic                         PERIPH_RUN,
  output logic                         FAST_OSC_STOP
);
  import mvic_pkg::*;

  logic [15:0]       src_all;
  logic [9:0]        vec_req;
  mvic_lvl_type      vec_lvl [NUM_VEC];
  logic              win_found;
  logic [3:0]        win_idx;
  mvic_lvl_type      win_lvl;
  mvic_lvl_type      cur_lvl;
  logic              accept_ok;
  logic              pin_c_raw;
  logic [2:0]        filt_reg;
  logic [2:0]        filt_next;
  logic              pin_c_q_reg;
  logic              pin_c_q_next;
  logic              pin_c_path;
  logic              pin_c_flag_reg;
  logic              pin_c_flag_next;
  logic              c_edge;
  logic [5:0]        pin_level;
  logic [5:0]        pin_hit;
  logic              hold_release;
  logic              any_reset;
  mvic_sb_type       sb_reg;
  mvic_sb_type       sb_next;
  mvic_of_type       of_reg;
  mvic_of_type       of_next;
  mvic_offer_type    offer_reg;
  mvic_offer_type    offer_next;
  logic [3:0]        offer_idx_reg;
  logic [3:0]        offer_idx_next;
  logic [2:0]        insvc_reg;
  logic [2:0]        insvc_next;

  // Pin C source: comparator replaces the pin when routed
  assign pin_c_raw = CMP_TO_PIN_C ? CMP_OUT : EXT_PIN[PIN_C];

  // Optional noise filter: all samples must agree before the path moves
  always_comb begin
    filt_next    = {filt_reg[1:0], pin_c_raw};
    pin_c_q_next = pin_c_q_reg;
    if (!PIN_C_FILTER_EN) begin
      pin_c_q_next = pin_c_raw;
    end else if (filt_reg == {FILT_LEN{1'b1}}) begin
      pin_c_q_next = 1'b1;
    end else if (filt_reg == {FILT_LEN{1'b0}}) begin
      pin_c_q_next = 1'b0;
    end
  end

  // Edge detection sets the pin C flag; a set beats a clear
  assign pin_c_path = pin_c_q_next;
  assign c_edge     = (PIN_C_RISE && pin_c_path && !pin_c_q_reg) ||
                      (PIN_C_FALL && !pin_c_path && pin_c_q_reg);
  always_comb begin
    pin_c_flag_next = pin_c_flag_reg;
    if (PIN_C_FLAG_CLR) begin
      pin_c_flag_next = 1'b0;
    end
    if (c_edge) begin
      pin_c_flag_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      filt_reg       <= FILT_RST;
      pin_c_q_reg    <= 1'b0;
      pin_c_flag_reg <= 1'b0;
    end else begin
      filt_reg       <= filt_next;
      pin_c_q_reg    <= pin_c_q_next;
      pin_c_flag_reg <= pin_c_flag_next;
    end
  end
  assign PIN_C_FLAG = pin_c_flag_reg;

  // Source word with the internal pin C flag merged in
  always_comb begin
    src_all            = SRC_FLAGS;
    src_all[SRC_PIN_C] = SRC_FLAGS[SRC_PIN_C] | pin_c_flag_reg;
  end

  // Sixteen sources folded onto ten vectors, the last one empty
  assign vec_req[0] = src_all[SRC_PIN_A];
  assign vec_req[1] = src_all[SRC_PIN_B];
  assign vec_req[2] = src_all[SRC_PIN_C] | src_all[SRC_T0L] | src_all[SRC_PIN_E];
  assign vec_req[3] = src_all[SRC_PIN_D] | src_all[SRC_PIN_F];
  assign vec_req[4] = src_all[SRC_T0H] | src_all[SRC_SIO];
  assign vec_req[5] = src_all[SRC_T1L] | src_all[SRC_T1H];
  assign vec_req[6] = src_all[SRC_PULSE_COUNTER1_EVENT];
  assign vec_req[7] = src_all[SRC_PULSE_COUNTER2_EVENT];
  assign vec_req[8] = src_all[SRC_ADC] | src_all[SRC_PWM_STOP] | src_all[SRC_PWM_CYC];
  assign vec_req[9] = 1'b0;

  // Per-vector level: first two choose top or low, rest high or low
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_lvl
    if (v < 2) begin : g_top
      assign vec_lvl[v] = LEVEL_UPPER[v] ? LVL_X : LVL_L;
    end else begin : g_high
      assign vec_lvl[v] = LEVEL_UPPER[v] ? LVL_H : LVL_L;
    end
  end

  mvic_arbiter #(
    .N     (NUM_VEC)
  ) u_arb (
    .req   (vec_req),
    .lvl   (vec_lvl),
    .found (win_found),
    .idx   (win_idx),
    .level (win_lvl)
  );

  // Level of the interrupt now in service, highest nested one
  always_comb begin
    cur_lvl = LVL_NONE;
    if (insvc_reg[2]) begin
      cur_lvl = LVL_X;
    end else if (insvc_reg[1]) begin
      cur_lvl = LVL_H;
    end else if (insvc_reg[0]) begin
      cur_lvl = LVL_L;
    end
  end
  assign accept_ok = win_found && (win_lvl > cur_lvl);

  // Offer sequencer and in-service tracking
  always_comb begin
    of_next        = of_reg;
    offer_next     = offer_reg;
    offer_idx_next = offer_idx_reg;
    insvc_next     = insvc_reg;
    if (IRQ_RETURN) begin
      if (insvc_reg[2]) begin
        insvc_next[2] = 1'b0;
      end else if (insvc_reg[1]) begin
        insvc_next[1] = 1'b0;
      end else begin
        insvc_next[0] = 1'b0;
      end
    end
    unique case (of_reg)
      OF_IDLE: begin
        if (accept_ok && (sb_reg != SB_HOLD)) begin
          of_next          = OF_OFFER;
          offer_idx_next   = win_idx;
          offer_next.level = win_lvl;
          offer_next.vector = VEC_BASE + (VEC_STEP * 20'(win_idx));
        end
      end
      OF_OFFER: begin
        if (IRQ_ACK) begin
          of_next = OF_IDLE;
          unique case (offer_reg.level)
            LVL_X:   insvc_next[2] = 1'b1;
            LVL_H:   insvc_next[1] = 1'b1;
            default: insvc_next[0] = 1'b1;
          endcase
        end else if (!vec_req[offer_idx_reg]) begin
          of_next = OF_IDLE; // Source cleared before being taken
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      of_reg        <= OF_IDLE;
      offer_reg     <= '0;
      offer_idx_reg <= 4'h0;
      insvc_reg     <= INSVC_RST;
    end else begin
      of_reg        <= of_next;
      offer_reg     <= offer_next;
      offer_idx_reg <= offer_idx_next;
      insvc_reg     <= insvc_next;
    end
  end
  assign IRQ_REQ    = (of_reg == OF_OFFER);
  assign IRQ_OFFER  = offer_reg;
  assign IN_SERVICE = insvc_reg;

  // Hold release: pin at its level; A and B only in level mode
  assign pin_level = {EXT_PIN[5:3], pin_c_raw, EXT_PIN[1:0]};
  always_comb begin
    pin_hit = ~(pin_level ^ PIN_LEVEL_HIGH);
    pin_hit[PIN_A] = pin_hit[PIN_A] & PIN_AB_LEVEL_MODE[0];
    pin_hit[PIN_B] = pin_hit[PIN_B] & PIN_AB_LEVEL_MODE[1];
  end
  assign hold_release = |pin_hit;
  assign any_reset    = !RST_PIN_N || WDT_RESET || BOD_RESET;

  // Standby state machine
  always_comb begin
    sb_next = sb_reg;
    unique case (sb_reg)
      SB_RUN: begin
        if (HOLD_ENTER) begin
          sb_next = SB_HOLD;
        end else if (HALT_ENTER) begin
          sb_next = SB_HALT;
        end
      end
      SB_HALT: begin
        if (any_reset || accept_ok) begin
          sb_next = SB_RUN;
        end
      end
      SB_HOLD: begin
        if (any_reset || hold_release) begin
          sb_next = SB_RUN;
        end
      end
      default: sb_next = SB_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sb_reg <= SB_RUN;
    end else begin
      sb_reg <= sb_next;
    end
  end
  assign CPU_RUN       = (sb_reg == SB_RUN);
  assign PERIPH_RUN    = (sb_reg != SB_HOLD);
  assign FAST_OSC_STOP = (sb_reg == SB_HOLD);

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_REFUSE_LOW: assert property ((of_reg == OF_IDLE) && win_found && (win_lvl <= cur_lvl)
    |=> of_reg == OF_IDLE) else $error("Request at or below serviced level was offered");
  AST_OFFER_ABOVE: assert property ($rose(IRQ_REQ) |-> IRQ_OFFER.level > $past(cur_lvl))
    else $error("Offered level not above serviced level");
  AST_HIGHEST: assert property ((of_reg == OF_IDLE) && accept_ok && (sb_reg != SB_HOLD)
    |=> IRQ_OFFER.level == $past(win_lvl)) else $error("Offer is not the highest level");
  AST_VECTOR: assert property (IRQ_REQ |-> IRQ_OFFER.vector == VEC_BASE + VEC_STEP * 20'(offer_idx_reg))
    else $error("Vector address wrong");
  AST_LOW_IDX: assert property ($rose(IRQ_REQ) && $past(vec_req[0]) && ($past(vec_lvl[0]) == IRQ_OFFER.level)
    |-> offer_idx_reg == 4'h0) else $error("Lower vector lost at equal level");
  AST_NO_EMPTY: assert property (IRQ_REQ |-> offer_idx_reg != 4'h9)
    else $error("Empty vector offered");
  AST_TOP_LVL: assert property (IRQ_REQ && (IRQ_OFFER.level == LVL_X) |-> offer_idx_reg < 4'h2)
    else $error("Top level on wrong vector");
  AST_HALT_WAKE: assert property ((sb_reg == SB_HALT) && accept_ok |=> CPU_RUN)
    else $error("Accepted interrupt did not end halt");
  AST_HOLD_OUT: assert property ((sb_reg == SB_HOLD) |-> !PERIPH_RUN && FAST_OSC_STOP && !CPU_RUN)
    else $error("Hold outputs wrong");
  AST_HOLD_WAKE: assert property ((sb_reg == SB_HOLD) && hold_release && !HOLD_ENTER |=> sb_reg == SB_RUN)
    else $error("Pin level did not end hold");
  AST_RESET_WAKE: assert property ((sb_reg != SB_RUN) && any_reset |=> CPU_RUN)
    else $error("Reset did not end standby");
  AST_PENDING: assert property (IRQ_REQ && !IRQ_ACK && vec_req[offer_idx_reg] |=> IRQ_REQ)
    else $error("Pending offer dropped");
  AST_C_FLAG: assert property (c_edge |=> PIN_C_FLAG)
    else $error("Pin C edge lost");
endmodule // mvic_top
`default_nettype wire

// >>> dv/mvic_cpu_model.sv
// CPU core model that takes each interrupt offer after a chosen delay
`default_nettype none
module mvic_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irq_req,
  input  wire logic [1:0] ack_dly,
  output var  logic       irq_ack
);
  int wait_cnt;
  // Acknowledge only while an offer stands; pulse is one cycle wide
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt = 0;
      irq_ack <= 1'b0;
    end else if (irq_req && !irq_ack && wait_cnt >= int'(ack_dly)) begin
      irq_ack <= 1'b1;
    end else begin
      wait_cnt = (irq_req && !irq_ack) ? wait_cnt + 1 : 0;
      irq_ack <= 1'b0;
    end
  end
endmodule // mvic_cpu_model
`default_nettype wire

// >>> dv/test_mvic_top.sv
// Self-checking bench for the vectored interrupt controller
`default_nettype none
module test_mvic_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mvic_pkg::*;
  localparam int SRC_VEC [16] = '{0, 1, 2, 2, 2, 3, 3, 4, 4, 5, 5, 6, 7, 8, 8, 8};
  logic clk_sys, rst, irq_ack, irq_ret, halt_en, hold_en, irq_req, cpu_run, periph_run, fast_stop;
  logic cmp_out, cmp_to_c, filt_en, c_rise, c_fall, c_clr, c_flag, rst_pin_n, wdt_rst, bod_rst, req_seen;
  logic [15:0]    src;
  logic [9:0]     upper;
  logic [5:0]     ext_pin;
  logic [5:0]     pin_hi;
  logic [1:0]     ab_mode, dly;
  logic [2:0]     in_service;
  mvic_offer_type offer;
  logic [23:0]    exp_q[$];
  int             err_count, samples_checked, s;

  mvic_top mvic_top_i (.CLK_SYS(clk_sys), .RST(rst), .SRC_FLAGS(src), .LEVEL_UPPER(upper), .IRQ_ACK(irq_ack),
    .IRQ_RETURN(irq_ret), .IRQ_REQ(irq_req), .IRQ_OFFER(offer), .IN_SERVICE(in_service), .HALT_ENTER(halt_en),
    .HOLD_ENTER(hold_en), .EXT_PIN(ext_pin), .PIN_LEVEL_HIGH(pin_hi), .PIN_AB_LEVEL_MODE(ab_mode),
    .CMP_OUT(cmp_out), .CMP_TO_PIN_C(cmp_to_c), .PIN_C_FILTER_EN(filt_en), .PIN_C_RISE(c_rise),
    .PIN_C_FALL(c_fall), .PIN_C_FLAG_CLR(c_clr), .PIN_C_FLAG(c_flag), .RST_PIN_N(rst_pin_n),
    .WDT_RESET(wdt_rst), .BOD_RESET(bod_rst), .CPU_RUN(cpu_run), .PERIPH_RUN(periph_run),
    .FAST_OSC_STOP(fast_stop));
  mvic_cpu_model mvic_cpu_model_i (.clk(clk_sys), .rst(rst), .irq_req(irq_req), .ack_dly(dly), .irq_ack(irq_ack));

  // Clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    chk("expectations_left", 24'(exp_q.size()), 24'h0);
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected offer word: vector then level code
  function automatic logic [23:0] expv(input int idx, input logic up);
    logic [1:0] lv;
    lv = !up ? 2'h1 : (idx < 2 ? 2'h3 : 2'h2);
    return {2'h0, VEC_BASE + VEC_STEP * 20'(idx), lv};
  endfunction

  // Monitor: each new offer is compared with the oldest note, sampled mid-cycle once settled
  always @(negedge clk_sys) begin
    if (!rst && irq_req && !req_seen) begin
      if (exp_q.size() == 0) chk("unexpected_offer", {2'h0, offer}, 24'h0);
      else chk("irq_offer", {2'h0, offer}, exp_q.pop_front());
    end
    req_seen <= irq_req;
  end

  task automatic wait_for(input string name, ref logic sig, input logic exp);
    for (int n = 0; n < 10 && sig !== exp; n++) @(negedge clk_sys);
    chk(name, {23'h0, sig}, {23'h0, exp});
    if (sig !== exp) test_done();
  endtask

  // Wait for the CPU model to take the offer, then clear the served sources
  task automatic serve(input logic [15:0] bits);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq_ack !== 1'b1 && n < 60);
    chk("ack_seen", {23'h0, irq_ack}, 24'h1);
    if (irq_ack !== 1'b1) test_done();
    @(negedge clk_sys);
    src = src & ~bits;
  endtask

  task automatic ret;
    @(negedge clk_sys);
    irq_ret = 1'b1;
    @(negedge clk_sys);
    irq_ret = 1'b0;
  endtask

  task automatic pulse_sb(input logic hold);
    @(negedge clk_sys);
    halt_en = !hold;
    hold_en = hold;
    @(negedge clk_sys);
    halt_en = 1'b0;
    hold_en = 1'b0;
  endtask

  initial begin
    {irq_ret, halt_en, hold_en, cmp_out, cmp_to_c, filt_en, c_rise, c_fall, c_clr, wdt_rst, bod_rst} = '0;
    {src, upper, ext_pin, ab_mode, dly, req_seen} = '0;
    pin_hi = 6'h3F;
    rst = 1'b1;
    rst_pin_n = 1'b1;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(32'hd9bf));
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    // Random single sources at random levels and ack delays
    for (int k = 0; k < 12; k++) begin
      @(negedge clk_sys);
      s = $urandom_range(15);
      upper = {10{1'($urandom_range(1))}};
      dly = 2'($urandom_range(3));
      exp_q.push_back(expv(SRC_VEC[s], upper[0]));
      src = 16'h1 << s;
      serve(src);
      ret();
    end
    $display("test vector_map done");
    // Three at once: high wins, lows refused while high served, top nests
    @(negedge clk_sys);
    upper = 10'h080;
    exp_q.push_back(expv(7, 1'b1));
    src = 16'h1820;
    serve(16'h1000);
    repeat (6) @(negedge clk_sys);
    chk("refused_req", {23'h0, irq_req}, 24'h0);
    chk("in_service_high", {21'h0, in_service}, 24'h2);
    upper = 10'h081;
    exp_q.push_back(expv(0, 1'b1));
    src[0] = 1'b1;
    serve(16'h0001);
    @(negedge clk_sys);
    chk("in_service_nest", {21'h0, in_service}, 24'h6);
    exp_q.push_back(expv(3, 1'b0));
    exp_q.push_back(expv(6, 1'b0));
    ret();
    ret();
    serve(16'h0020);
    ret();
    serve(16'h0800);
    ret();
    $display("test nesting done");
    // Halt: CPU stops, peripherals and oscillators run, interrupt resumes
    upper = '0;
    pulse_sb(1'b0);
    chk("halt_state", {21'h0, cpu_run, periph_run, fast_stop}, 24'h2);
    exp_q.push_back(expv(4, 1'b0));
    src = 16'h0100;
    wait_for("halt_wake", cpu_run, 1'b1);
    serve(16'h0100);
    ret();
    $display("test halt done");
    // Hold: release by pins A, B and D, comparator on pin C, and each reset source in turn
    for (int w = 0; w < 7; w++) begin
      pulse_sb(1'b1);
      chk("hold_state", {21'h0, cpu_run, periph_run, fast_stop}, 24'h1);
      case (w)
        0: ext_pin[1:0] = 2'b11;
        1: ext_pin[3] = 1'b1;
        2: {cmp_to_c, cmp_out} = 2'b11;
        3: wdt_rst = 1'b1;
        4: bod_rst = 1'b1;
        5: rst_pin_n = 1'b0;
        default: {ab_mode, pin_hi[0]} = 3'b010;
      endcase
      if (w == 0) begin
        repeat (4) @(negedge clk_sys);
        chk("hold_kept_edge_mode", {23'h0, cpu_run}, 24'h0);
        ab_mode = 2'b10;
      end
      wait_for("hold_wake", cpu_run, 1'b1);
      @(negedge clk_sys);
      {ext_pin, cmp_to_c, cmp_out, wdt_rst, bod_rst, ab_mode} = '0;
      rst_pin_n = 1'b1;
      pin_hi = 6'h3F;
    end
    $display("test hold done");
    // Pin C flag: plain edge, glitch, filtered rise and fall; each set flag raises vector 2 at low level
    c_rise = 1'b1;
    c_clr = 1'b1;
    repeat (2) @(negedge clk_sys);
    c_clr = 1'b0;
    exp_q.push_back(expv(2, 1'b0));
    ext_pin[2] = 1'b1;
    wait_for("pin_c_edge", c_flag, 1'b1);
    serve(16'h0000);
    c_clr = 1'b1;
    ext_pin[2] = 1'b0;
    filt_en = 1'b1;
    ret();
    repeat (6) @(negedge clk_sys);
    c_clr = 1'b0;
    ext_pin[2] = 1'b1;
    @(negedge clk_sys);
    ext_pin[2] = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("pin_c_glitch", {23'h0, c_flag}, 24'h0);
    exp_q.push_back(expv(2, 1'b0));
    ext_pin[2] = 1'b1;
    wait_for("pin_c_filtered", c_flag, 1'b1);
    serve(16'h0000);
    {c_clr, c_rise, c_fall} = 3'b101;
    ret();
    c_clr = 1'b0;
    exp_q.push_back(expv(2, 1'b0));
    ext_pin[2] = 1'b0;
    wait_for("pin_c_fall", c_flag, 1'b1);
    serve(16'h0000);
    c_clr = 1'b1;
    ret();
    $display("test pin_c done");
    repeat (4) @(negedge clk_sys);
    test_done();
  end
endmodule // test_mvic_top
`default_nettype wire
